// File: hdl/mpag_pkg.sv
// Operation
// - One circular buffer in X space and one in Y; X also serves program pointers.
// - Any working pointer but pointer 15 may be circular; stack pointers are discouraged.
// - Power-of-two buffers are checked at both boundaries.
// - Four 16-bit boundary registers hold X and Y start and end.
// - Y circular addresses force the least significant bit to zero.
// - Length is end minus start plus one, never stored; at most 32K words.
// - X select in bits 3:0, enable bit 15; 1111 disables X.
// - Y select in bits 7:4, enable bit 14; 1111 disables Y.
// - Page register plus upper data address picks a 32-Kbyte window.
// - Read page of 0x200 or more directs paged reads to program space.
// - Program space is readable only; write page addresses data space only.
// - Paged reads use the read page, paged writes the write page.
// - Each access names one of six addressing modes.
// - Upper 32 Kbytes of base data space is the paged window.
package mpag_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CONTROL = 8'h00;
  localparam logic [7:0]  OFS_XSTART  = 8'h04;
  localparam logic [7:0]  OFS_XEND    = 8'h08;
  localparam logic [7:0]  OFS_YSTART  = 8'h0c;
  localparam logic [7:0]  OFS_YEND    = 8'h10;
  localparam logic [7:0]  OFS_RDPAGE  = 8'h14;
  localparam logic [7:0]  OFS_WRPAGE  = 8'h18;
  localparam logic [7:0]  OFS_STATUS  = 8'h1c;
  // ----------------------------------------------------------------
  // Field layout and constants
  // ----------------------------------------------------------------
  localparam int          XSEL_LSB    = 0;
  localparam int          YSEL_LSB    = 4;
  localparam int          XEN_BIT     = 15;
  localparam int          YEN_BIT     = 14;
  localparam logic [3:0]  SEL_OFF     = 4'hf;
  localparam logic [15:0] CTRL_RESET  = 16'h00ff;
  localparam logic [15:0] BOUND_RESET = 16'h0000;
  localparam logic [9:0]  RDPAGE_RST  = 10'h001;
  localparam logic [8:0]  WRPAGE_RST  = 9'h001;
  localparam logic [9:0]  PS_PAGE_MIN = 10'h200;
  localparam int          WIN_BIT     = 15;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;

  // Addressing modes of an access
  typedef enum logic [2:0] {
    MPAG_INHERENT, MPAG_RELATIVE, MPAG_LITERAL,
    MPAG_MEM_DIRECT, MPAG_REG_DIRECT, MPAG_REG_INDIRECT
  } mpag_mode_t;

  // Request from the execution unit
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       y_space;
    mpag_mode_t mode;
    logic [3:0] ptr_reg;
    logic [15:0] ea;
    logic signed [15:0] step;
  } mpag_req_t;

  // Resolved access towards memory
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        prog;
    logic        paged;
    logic [23:0] addr;
    logic        ptr_we;
    logic [3:0]  ptr_reg;
    logic [15:0] ptr_next;
  } mpag_acc_t;
endpackage : mpag_pkg

// File: hdl/mpag_top.sv
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module mpag_top (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire mpag_pkg::mpag_req_t req,
  output mpag_pkg::mpag_acc_t      acc
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] ctrl;
  logic [15:0] xs, xe, ys, ye;
  logic [9:0]  rdpage;
  logic [8:0]  wrpage;
  logic        last_wrap;
  logic        last_prog;
  logic        ph_wr;
  logic [7:0]  ph_addr;

  // Selected pointer matches and is enabled
  function automatic logic mod_on(input logic [15:0] c, input int lsb,
                                  input int en, input logic [3:0] r);
    logic [3:0] s;
    s = c[lsb +: 4];
    return c[en] && (s != mpag_pkg::SEL_OFF) && (s == r);
  endfunction : mod_on

  // ----------------------------------------------------------------
  // Bus slave address phase
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr   <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_wr   <= hsel && htrans == mpag_pkg::HTRANS_NSEQ && hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl   <= mpag_pkg::CTRL_RESET;
      xs     <= mpag_pkg::BOUND_RESET;
      xe     <= mpag_pkg::BOUND_RESET;
      ys     <= mpag_pkg::BOUND_RESET;
      ye     <= mpag_pkg::BOUND_RESET;
      rdpage <= mpag_pkg::RDPAGE_RST;
      wrpage <= mpag_pkg::WRPAGE_RST;
    end else if (ph_wr) begin
      case (ph_addr)
        mpag_pkg::OFS_CONTROL: ctrl   <= hwdata[15:0];
        mpag_pkg::OFS_XSTART:  xs     <= hwdata[15:0];
        mpag_pkg::OFS_XEND:    xe     <= hwdata[15:0];
        mpag_pkg::OFS_YSTART:  ys     <= hwdata[15:0];
        mpag_pkg::OFS_YEND:    ye     <= hwdata[15:0];
        mpag_pkg::OFS_RDPAGE:  rdpage <= hwdata[9:0];
        mpag_pkg::OFS_WRPAGE:  wrpage <= hwdata[8:0];
        default: ;
      endcase
    end
  end

  // Read data, registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans == mpag_pkg::HTRANS_NSEQ) begin
      case (haddr[7:0])
        mpag_pkg::OFS_CONTROL: hrdata <= {16'h0000, ctrl};
        mpag_pkg::OFS_XSTART:  hrdata <= {16'h0000, xs};
        mpag_pkg::OFS_XEND:    hrdata <= {16'h0000, xe};
        mpag_pkg::OFS_YSTART:  hrdata <= {16'h0000, ys};
        mpag_pkg::OFS_YEND:    hrdata <= {16'h0000, ye};
        mpag_pkg::OFS_RDPAGE:  hrdata <= {22'h000000, rdpage};
        mpag_pkg::OFS_WRPAGE:  hrdata <= {23'h000000, wrpage};
        mpag_pkg::OFS_STATUS:  hrdata <= {30'h00000000, last_prog,
                                          last_wrap};
        default:               hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Circular pointer update
  // ----------------------------------------------------------------
  logic        circ;
  logic [15:0] lo, hi, raw, next_ptr, ea_eff;
  logic [16:0] len;
  logic        pow2;
  always_comb begin
    // One buffer per space; X also serves program reads
    if (req.y_space) begin
      circ = mod_on(ctrl, mpag_pkg::YSEL_LSB, mpag_pkg::YEN_BIT,
                    req.ptr_reg);
      lo   = {ys[15:1], 1'b0};
      hi   = {ye[15:1], 1'b0};
    end else begin
      circ = mod_on(ctrl, mpag_pkg::XSEL_LSB, mpag_pkg::XEN_BIT,
                    req.ptr_reg);
      lo   = xs;
      hi   = xe;
    end
    // Length from boundaries only, up to 64 Kbytes
    len  = 17'({1'b0, hi} - {1'b0, lo}) + 17'h00001;
    pow2 = (len & (len - 17'h00001)) == 17'h00000;
    // Y pointer arithmetic starts from the word-aligned address
    ea_eff = req.y_space ? {req.ea[15:1], 1'b0} : req.ea;
    raw  = ea_eff + 16'(req.step);
    next_ptr = raw;
    // Both boundaries checked; direction left to software
    if (circ && req.mode == mpag_pkg::MPAG_REG_INDIRECT) begin
      if (req.step > 0 && raw > hi)
        next_ptr = 16'(raw - len[15:0]);
      else if (req.step < 0 && raw < lo)
        next_ptr = 16'(raw + len[15:0]);
    end
    if (req.y_space)
      next_ptr[0] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Paged address formation
  // ----------------------------------------------------------------
  logic        paged, to_prog;
  logic [23:0] full;
  always_comb begin
    paged   = ea_eff[mpag_pkg::WIN_BIT];
    to_prog = paged && !req.write &&
              rdpage >= mpag_pkg::PS_PAGE_MIN;
    if (!paged)
      full = {8'h00, ea_eff};
    else if (req.write)
      full = {wrpage, ea_eff[14:0]};
    else
      full = {rdpage[8:0], ea_eff[14:0]};
  end

  // Registered access output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc       <= '0;
      last_wrap <= 1'b0;
      last_prog <= 1'b0;
    end else begin
      acc.valid    <= req.valid;
      acc.write    <= req.write;
      acc.prog     <= to_prog;
      acc.paged    <= paged;
      acc.addr     <= full;
      acc.ptr_we   <= req.valid &&
                      req.mode == mpag_pkg::MPAG_REG_INDIRECT;
      acc.ptr_reg  <= req.ptr_reg;
      acc.ptr_next <= next_ptr;
      if (req.valid) begin
        last_wrap <= next_ptr != raw;
        last_prog <= to_prog;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_x_wrap_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (req.valid && !req.y_space && req.step == 16'sd1 &&
     req.mode == mpag_pkg::MPAG_REG_INDIRECT &&
     mod_on(ctrl, 0, 15, req.ptr_reg) && req.ea == xe && xe > xs)
    |=> acc.ptr_next == $past(xs))
    else $error("X increment did not reload start");
  a_sel_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (req.valid && !req.y_space && ctrl[3:0] == 4'hf)
    |=> acc.ptr_next == $past(raw))
    else $error("X circular active with select off");
  a_y_lsb_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (req.valid && req.y_space) |=> !acc.ptr_next[0])
    else $error("Y pointer lsb set");
  a_ps_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (req.valid && !req.write && req.ea[15] && rdpage >= 10'h200)
    |=> acc.prog)
    else $error("Paged read missed program space");
  a_no_ps_write: assert property (@(posedge hclk) disable iff (!hresetn)
    acc.write |-> !acc.prog)
    else $error("Write directed to program space");
  a_wr_page: assert property (@(posedge hclk) disable iff (!hresetn)
    (req.valid && req.write && req.ea[15])
    |=> acc.addr[23:15] == $past(wrpage))
    else $error("Write did not use write page");
  a_unpaged: assert property (@(posedge hclk) disable iff (!hresetn)
    (req.valid && !req.ea[15]) |=> !acc.paged && acc.addr[23:16] == 8'h00)
    else $error("Lower half was paged");
  a_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
    ph_wr && ph_addr == 8'h00 |=> ctrl == $past(hwdata[15:0]))
    else $error("Control write lost");
endmodule : mpag_top

// File: testbench/mpag_exec_model.sv
`timescale 1ns/1ps
// Execution unit stand-in: pointer file and request issue
module mpag_exec_model (
  input  wire logic                hclk,
  input  wire mpag_pkg::mpag_acc_t acc,
  output mpag_pkg::mpag_req_t      req
);
  logic [15:0] wreg [16];
  // Pointer write-back from the generator
  always @(posedge hclk) begin
    if (acc.valid && acc.ptr_we) begin
      wreg[acc.ptr_reg] <= acc.ptr_next;
    end
  end
  // One request, operand address from the pointer
  task automatic issue(input logic w, y, input mpag_pkg::mpag_mode_t m,
                       input logic [3:0] p, input logic [15:0] s);
    req <= {1'b1, w, y, m, p, wreg[p], s};
  endtask : issue
  // Released request: fields flipped, never stale
  task automatic idle();
    req <= {1'b0, ~req[40:0]};
  endtask : idle
  initial req = '0;
endmodule : mpag_exec_model

// File: testbench/mpag_top_tb.sv
`timescale 1ns/1ps
module mpag_top_tb;
  localparam mpag_pkg::mpag_mode_t IND = mpag_pkg::MPAG_REG_INDIRECT;
  logic                hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]         haddr, hwdata, hrdata, rd, v;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  mpag_pkg::mpag_req_t req;
  mpag_pkg::mpag_acc_t acc, ex;
  logic [15:0]         sh [8];
  logic [15:0]         cv [3];
  logic [7:0]          ofs [8];
  logic [31:0]         rst [8];
  logic [31:0]         msk [8];
  int                  n_fail, checked, seed, i, k;

  assign hready = hreadyout;
  mpag_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .req(req), .acc(acc));
  mpag_exec_model peer (.hclk(hclk), .acc(acc), .req(req));

  // Clock generation
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Single AHB-Lite word transfer, read data left in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= mpag_pkg::HTRANS_NSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= mpag_pkg::HSIZE_WORD;
    k = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && k++ < 99);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && k++ < 99);
    rd = hrdata;
    if (k >= 99) n_fail++;
  endtask : bus

  // Register write with shadow copy
  task automatic cfg(input int j, input logic [31:0] d);
    bus(1'b1, ofs[j], d);
    sh[j] = d[15:0] & msk[j][15:0];
  endtask : cfg

  // Reference address generation
  function automatic mpag_pkg::mpag_acc_t model(input mpag_pkg::mpag_req_t r);
    mpag_pkg::mpag_acc_t a;
    logic [3:0]          sel;
    logic [15:0]         e;
    int                  lo, hi, nx;
    a = '0;
    e = r.ea;
    sel = r.y_space ? sh[0][7:4] : sh[0][3:0];
    lo = r.y_space ? sh[3] & 16'hfffe : sh[1];
    hi = r.y_space ? sh[4] & 16'hfffe : sh[2];
    e[0] = e[0] & !r.y_space;
    nx = e;
    nx += r.step;
    if (r.mode == IND && sel == r.ptr_reg && sel != mpag_pkg::SEL_OFF &&
        sh[0][r.y_space ? 14 : 15]) begin
      if (r.step > 0 && nx > hi) nx -= hi - lo + 1;
      if (r.step < 0 && nx < lo) nx += hi - lo + 1;
    end
    a.ptr_we = r.mode == IND;
    a.ptr_next = nx[15:0] & {15'h7fff, !r.y_space};
    a.valid = r.valid;
    a.write = r.write;
    a.paged = e[15];
    a.prog = e[15] && !r.write && sh[5] >= 16'h0200;
    a.addr = !e[15] ? {8'h00, e} : r.write ? {sh[6][8:0], e[14:0]}
           : {sh[5][8:0], e[14:0]};
    return a;
  endfunction : model

  // One access through the execution unit, then write-back check
  task automatic access(input logic w, y, input mpag_pkg::mpag_mode_t m,
                        input logic [3:0] p, input logic [15:0] e, s);
    ex = model({1'b1, w, y, m, p, e, s});
    @(posedge hclk);
    peer.wreg[p] = e;
    peer.issue(w, y, m, p, s);
    @(posedge hclk);
    peer.idle();
    #1;
    chk({acc[48:45], 4'h0, acc.addr}, {ex[48:45], 4'h0, ex.addr});
    if (ex.ptr_we || m != IND) chk(acc.ptr_we, ex.ptr_we);
    @(posedge hclk);
    #1;
    if (ex.ptr_we) chk(peer.wreg[p], ex.ptr_next);
  endtask : access

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // Watchdog against a hung transfer
  initial begin
    #500000;
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    seed = 86750;
    n_fail = 0;
    checked = 0;
    ofs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    rst = '{32'hff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0};
    msk = '{32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'h3ff,
            32'h1ff, 32'h0};
    cv = '{16'h4032, 16'hc0ff, 16'h8032};
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = 72'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, random read-back, status word
    for (i = 0; i < 8; i++) begin
      bus(1'b0, ofs[i], 32'h0);
      chk(rd, rst[i]);
      v = $random(seed);
      cfg(i, v);
      bus(1'b0, ofs[i], 32'h0);
      chk(rd, v & msk[i]);
    end
    // Circular X on pointer 2, Y on pointer 3
    cfg(1, 32'h1000);
    cfg(2, 32'h100f);
    cfg(3, 32'h2000);
    cfg(4, 32'h200f);
    cfg(0, 32'hc032);
    access(1'b0, 1'b0, IND, 4'h2, 16'h100e, 16'h2);
    access(1'b0, 1'b0, IND, 4'h2, 16'h100f, 16'h1);
    access(1'b0, 1'b0, IND, 4'h2, 16'h1000, 16'hfffe);
    access(1'b1, 1'b0, IND, 4'h5, 16'h100e, 16'h2);
    access(1'b0, 1'b1, IND, 4'h3, 16'h200f, 16'h2);
    for (i = 0; i < 6; i++) begin
      access(1'b1, 1'b0, mpag_pkg::mpag_mode_t'(i), 4'h2, 16'h100e, 16'h2);
    end
    for (i = 0; i < 3; i++) begin
      cfg(0, {16'h0, cv[i]});
      access(1'b0, 1'b0, IND, 4'h2, 16'h100e, 16'h2);
      access(1'b0, 1'b1, IND, 4'h3, 16'h200e, 16'h2);
    end
    // Paged reads and writes around the program space threshold
    cv = '{16'h01ff, 16'h0200, 16'h03ff};
    for (i = 0; i < 3; i++) begin
      cfg(5, {16'h0, cv[i]});
      cfg(6, {16'h0, cv[i] ^ 16'h00a5});
      access(1'b0, 1'b0, mpag_pkg::MPAG_MEM_DIRECT, 4'h0, 16'h8246, 16'h0);
      access(1'b1, 1'b0, mpag_pkg::MPAG_MEM_DIRECT, 4'h0, 16'hfffe, 16'h0);
    end
    // Random traffic on pointers 4 to 13
    repeat (30) begin
      v = $random(seed);
      access(v[0], v[1], mpag_pkg::mpag_mode_t'(v[4:2] % 6),
             4'(4 + v[8:5] % 10), v[31:16] & 16'hfffe,
             {{12{v[12]}}, v[12:10], 1'b0});
    end
    conclude();
  end
endmodule : mpag_top_tb
